// ==== design/eip_arbiter.sv ====
// fixed-order two-level request arbiter
module eip_arbiter
  import eip_pkg::*;
(
  input  wire logic [NUM_SRC-1:0] req,
  input  wire logic [NUM_SRC-1:0] level,
  output logic                    any,
  output logic      [3:0]         src,
  output logic                    src_level
);

  // scan downward so the lowest numbered source is the last to win
  always_comb begin
    any       = 1'b0;
    src       = 4'h0;
    src_level = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i] && level[i]) begin
        any       = 1'b1;
        src       = 4'(i);
        src_level = 1'b1;
      end
    end
    if (!src_level) begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (req[i]) begin
          any = 1'b1;
          src = 4'(i);
        end
      end
    end
  end

endmodule

// ==== design/eip_ctrl.sv ====
// external request flags, priority registers and request presentation
//
// Chosen here: the Wishbone register port.
module eip_ctrl
  import eip_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [11:0]        wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic [NUM_EXT-1:0] external_request_input_n,
  input  wire logic [NUM_EXT-1:0] request_sense_select,
  input  wire logic [NUM_EXT-1:0] request_input_enable,
  input  wire logic [NUM_PER-1:0] periph_req,
  input  wire logic               exc_take,
  input  wire logic [3:0]         exc_src,
  output logic                    cpu_req,
  output logic      [3:0]         cpu_src,
  output logic                    cpu_level,
  output logic                    irq_o
);

  typedef struct packed {
    logic               ack;
    logic [31:0]        rdata;
    logic [7:0]         prio_a;
    logic [7:0]         prio_b;
    logic [NUM_EXT-1:0] flag;
    logic [NUM_EXT-1:0] read_seen;
    logic [NUM_EXT-1:0] pin_prev;
    logic [NUM_EXT-1:0] evt;
    logic [NUM_EXT-1:0] mask;
    logic               req;
    logic [3:0]         src;
    logic               level;
  } eip_ctrl_st_t;

  localparam eip_ctrl_st_t ST_RESET = '{
    ack:       1'b0,
    rdata:     32'h0000_0000,
    prio_a:    PRIO_A_RESET,
    prio_b:    PRIO_B_RESET,
    flag:      FLAG_RESET,
    read_seen: FLAG_RESET,
    pin_prev:  PIN_IDLE,
    evt:       FLAG_RESET,
    mask:      MASK_RESET,
    req:       1'b0,
    src:       4'h0,
    level:     1'b0
  };

  eip_ctrl_st_t st_ff;
  eip_ctrl_st_t nxt_st;

  logic [NUM_EXT-1:0] pin_sync;
  logic [NUM_SRC-1:0] src_req;
  logic [NUM_SRC-1:0] src_lvl;
  logic               arb_any;
  logic [3:0]         arb_src;
  logic               arb_level;

  // word index of a byte address; anything off a word boundary misses every register
  function automatic logic [7:0] reg_index(input logic [11:0] adr);
    reg_index = (adr[1:0] == 2'b00) ? adr[9:2] : 8'h00;
  endfunction

  // spread the compact flag vector onto its status bit positions
  function automatic logic [7:0] spread(input logic [NUM_EXT-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < NUM_EXT; k++) begin
      r[FLAG_POS[k*8 +: 3]] = v[k];
    end
    spread = r;
  endfunction

  // gather the status bit positions back into the compact flag vector
  function automatic logic [NUM_EXT-1:0] gather(input logic [7:0] d);
    logic [NUM_EXT-1:0] r;
    r = '0;
    for (int k = 0; k < NUM_EXT; k++) begin
      r[k] = d[FLAG_POS[k*8 +: 3]];
    end
    gather = r;
  endfunction

  // priority bit of one source: 0 puts it at the low level, 1 at the high
  function automatic logic prio_of(input logic [7:0] pa, input logic [7:0] pb, input int s);
    logic [3:0] sel;
    sel = SRC_PRIO_BIT[s*4 +: 4];
    prio_of = sel[3] ? pb[sel[2:0]] : pa[sel[2:0]];
  endfunction

  eip_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   (external_request_input_n),
    .pin_sync (pin_sync)
  );

  // external requests reach the arbiter only while enabled
  assign src_req[NUM_EXT-1:0]       = st_ff.flag & request_input_enable;
  assign src_req[NUM_SRC-1:NUM_EXT] = periph_req;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_lvl
      assign src_lvl[g] = prio_of(st_ff.prio_a, st_ff.prio_b, g);
    end
  endgenerate

  eip_arbiter u_arb (
    .req       (src_req),
    .level     (src_lvl),
    .any       (arb_any),
    .src       (arb_src),
    .src_level (arb_level)
  );

  always_comb begin
    logic                take;
    logic                wr;
    logic                rd;
    logic [7:0]          idx;
    logic [7:0]          wbyte;
    logic [NUM_EXT-1:0]  wflag;
    logic [NUM_EXT-1:0]  set_ev;
    logic [NUM_EXT-1:0]  clr_sw;
    logic [NUM_EXT-1:0]  clr_hw;
    logic [NUM_EXT-1:0]  exc_hit;
    logic [31:0]         rd_word;
    take    = wb_cyc_i && wb_stb_i && !st_ff.ack;
    wr      = take && wb_we_i && wb_sel_i[0];
    rd      = take && !wb_we_i;
    idx     = reg_index(wb_adr_i);
    wbyte   = wb_dat_i[7:0];
    wflag   = gather(wbyte);
    set_ev  = '0;
    clr_sw  = '0;
    clr_hw  = '0;
    exc_hit = '0;
    rd_word = 32'h0000_0000;
    nxt_st  = st_ff;

    nxt_st.ack      = take;
    nxt_st.pin_prev = pin_sync;

    for (int k = 0; k < NUM_EXT; k++) begin
      exc_hit[k] = exc_take && (exc_src == 4'(k));
      if (request_sense_select[k] == SENSE_LEVEL) begin
        set_ev[k] = !pin_sync[k];
        clr_hw[k] = exc_hit[k] && pin_sync[k];
      end else begin
        set_ev[k] = st_ff.pin_prev[k] && !pin_sync[k];
        clr_hw[k] = exc_hit[k];
      end
      // only a zero clears, and only after the flag was seen as one
      clr_sw[k] = wr && (idx == IDX_STATUS) && !wflag[k] && st_ff.read_seen[k];
    end

    // a setting condition in the same cycle as any clear keeps the flag set
    nxt_st.flag = set_ev | (st_ff.flag & ~clr_sw & ~clr_hw);

    // a read that returns one arms the clear; the next status write disarms it
    if (rd && idx == IDX_STATUS) begin
      nxt_st.read_seen = st_ff.read_seen | st_ff.flag;
    end else if (wr && idx == IDX_STATUS) begin
      nxt_st.read_seen = '0;
    end
    nxt_st.read_seen = nxt_st.read_seen & nxt_st.flag;

    // event bits catch each new rising of a flag; write one to clear
    if (wr && idx == IDX_EVT) begin
      nxt_st.evt = st_ff.evt & ~wflag;
    end
    nxt_st.evt = nxt_st.evt | (set_ev & ~st_ff.flag);

    if (wr) begin
      if (idx == IDX_PRIO_A) begin
        nxt_st.prio_a = wbyte;
      end else if (idx == IDX_PRIO_B) begin
        nxt_st.prio_b = wbyte;
      end else if (idx == IDX_MASK) begin
        nxt_st.mask = wflag;
      end
    end

    // unmapped words read as zero and ignore writes
    if (idx == IDX_STATUS) begin
      rd_word[7:0] = spread(st_ff.flag);
    end else if (idx == IDX_PRIO_A) begin
      rd_word[7:0] = st_ff.prio_a;
    end else if (idx == IDX_PRIO_B) begin
      rd_word[7:0] = st_ff.prio_b;
    end else if (idx == IDX_EVT) begin
      rd_word[7:0] = spread(st_ff.evt);
    end else if (idx == IDX_MASK) begin
      rd_word[7:0] = spread(st_ff.mask);
    end else if (idx == IDX_PENDING) begin
      rd_word = {st_ff.req, st_ff.level, 1'b0, st_ff.src, 12'h000, src_req};
    end
    if (rd) begin
      nxt_st.rdata = rd_word;
    end

    // presented request is a cycle behind the flags; a taken source drops out first
    nxt_st.req   = arb_any && !(exc_take && exc_src == arb_src);
    nxt_st.src   = arb_src;
    nxt_st.level = arb_level;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o  = st_ff.ack;
  assign wb_dat_o  = st_ff.rdata;
  assign cpu_req   = st_ff.req;
  assign cpu_src   = st_ff.src;
  assign cpu_level = st_ff.level;
  assign irq_o     = |(st_ff.evt & st_ff.mask);

endmodule

// ==== design/eip_pkg.sv ====
// constants for the external request flags and priority block
package eip_pkg;

  localparam int NUM_EXT = 4;
  localparam int NUM_SRC = 13;
  localparam int NUM_PER = 9;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS  = 8'hf7;
  localparam logic [7:0] IDX_PRIO_A  = 8'hf8;
  localparam logic [7:0] IDX_PRIO_B  = 8'hf9;
  localparam logic [7:0] IDX_EVT     = 8'hfa;
  localparam logic [7:0] IDX_MASK    = 8'hfb;
  localparam logic [7:0] IDX_PENDING = 8'hfc;

  localparam logic [7:0] PRIO_A_RESET = 8'h00;
  localparam logic [7:0] PRIO_B_RESET = 8'h00;
  localparam logic [3:0] FLAG_RESET   = 4'h0;
  localparam logic [3:0] MASK_RESET   = 4'h0;
  localparam logic [3:0] PIN_IDLE     = 4'hf;

  // status bit position of each external flag, packed 8 bits per entry
  localparam logic [31:0] FLAG_POS = {8'h05, 8'h04, 8'h01, 8'h00};

  // source numbers; lower number wins within one level
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_EXT1 = 4'h1;
  localparam logic [3:0] SRC_EXT4 = 4'h2;
  localparam logic [3:0] SRC_EXT5 = 4'h3;
  localparam logic [3:0] SRC_WDT  = 4'h4;
  localparam logic [3:0] SRC_TMR0 = 4'h5;
  localparam logic [3:0] SRC_TMR1 = 4'h6;
  localparam logic [3:0] SRC_TMR2 = 4'h7;
  localparam logic [3:0] SRC_TMR3 = 4'h8;
  localparam logic [3:0] SRC_TMR4 = 4'h9;
  localparam logic [3:0] SRC_SCI0 = 4'ha;
  localparam logic [3:0] SRC_SCI1 = 4'hb;
  localparam logic [3:0] SRC_ADC  = 4'hc;

  // priority bit of each source, packed 4 bits per entry: bit 3 picks register b
  localparam logic [51:0] SRC_PRIO_BIT = {
    4'h9, 4'ha, 4'hb, 4'he, 4'hf, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h6, 4'h7};

  localparam logic SENSE_LEVEL = 1'b0;
  localparam logic SENSE_EDGE  = 1'b1;

endpackage

// ==== design/eip_sync.sv ====
// two-flop synchroniser for the external request pins
module eip_sync
  import eip_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [NUM_EXT-1:0] pin_in,
  output logic      [NUM_EXT-1:0] pin_sync
);

  typedef struct packed {
    logic [NUM_EXT-1:0] s1;
    logic [NUM_EXT-1:0] s2;
  } eip_sync_st_t;

  eip_sync_st_t st_ff;
  eip_sync_st_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
  end

  // pins idle high, so reset to that to avoid a false falling edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '{s1: PIN_IDLE, s2: PIN_IDLE};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_sync = st_ff.s2;

endmodule

// ==== test/eip_checker.sv ====
// port checks for the request flag and priority block
module eip_checker
  import eip_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic [NUM_EXT-1:0] external_request_input_n,
  input wire logic [NUM_EXT-1:0] request_sense_select,
  input wire logic [NUM_EXT-1:0] request_input_enable,
  input wire logic [NUM_PER-1:0] periph_req,
  input wire logic               exc_take,
  input wire logic [3:0]         exc_src,
  input wire logic               cpu_req,
  input wire logic [3:0]         cpu_src,
  input wire logic               cpu_level,
  input wire logic               irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_tk;
  assign rd_tk = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_holds: assert property (!$past(rd_tk) |-> $stable(wb_dat_o))
    else $error("read data changed without a read");
  a_level_sets: assert property (
    (!external_request_input_n[0] && !request_sense_select[0] && request_input_enable[0]) [*4] ##0 !exc_take
    |=> cpu_req)
    else $error("low level did not raise a request");
  a_edge_sets: assert property (
    (external_request_input_n[0] && request_sense_select[0]) ##1 (!external_request_input_n[0]
    && request_sense_select[0] && request_input_enable[0] && !exc_take) [*4] |=> cpu_req)
    else $error("falling edge did not raise a request");
  a_exc_clears: assert property (
    external_request_input_n[0] [*4] ##0 (exc_take && exc_src == SRC_EXT0)
    |-> ##2 !(cpu_req && cpu_src == SRC_EXT0))
    else $error("exception did not clear the flag");
  a_ext_enable: assert property (
    cpu_req && cpu_src < 4'h4 |-> (($past(request_input_enable) >> cpu_src[1:0]) & 4'h1) != 4'h0)
    else $error("disabled input forwarded");
  a_per_forward: assert property (
    cpu_req && cpu_src > 4'h3 |-> (($past(periph_req) >> (cpu_src - 4'h4)) & 9'h1) != 9'h0)
    else $error("winner without request");
  c_exc: cover property (exc_take);
  c_high: cover property (cpu_req && cpu_level);
  c_irq: cover property (irq_o);
endmodule

bind eip_ctrl eip_checker i_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .exc_take(exc_take), .exc_src(exc_src),
  .external_request_input_n(external_request_input_n), .request_sense_select(request_sense_select),
  .request_input_enable(request_input_enable), .periph_req(periph_req), .cpu_req(cpu_req),
  .cpu_src(cpu_src), .cpu_level(cpu_level), .irq_o(irq_o));

// ==== test/eip_cpu_model.sv ====
// cpu exception sequencer model answering presented requests
module eip_cpu_model (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       on,
  input wire logic [3:0] dly,
  input wire logic       cpu_req,
  input wire logic [3:0] cpu_src,
  output logic           exc_take,
  output logic     [3:0] exc_src
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_ff;
  // two spare cycles let cpu_req catch up after a take, so no double take
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_ff <= 4'h0;
      exc_take <= 1'b0;
      exc_src <= 4'h0;
    end else if (on && cpu_req && wait_ff == dly + 4'h2) begin
      exc_take <= 1'b1;
      exc_src <= cpu_src;
      wait_ff <= 4'h0;
    end else begin
      exc_take <= 1'b0;
      exc_src <= ~exc_src;
      wait_ff <= (on && cpu_req) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the request flag and priority block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import eip_pkg::*;
  logic               clk, rst_n, cyc, stb, we, ack, irq, creq, clvl, take, on;
  logic [11:0]        adr;
  logic [31:0]        wdat, rdat, rd, lfsr;
  logic [3:0]         pins, sense, en, csrc, esrc, dly;
  logic [NUM_PER-1:0] preq;
  logic [5:0]         w;
  logic [16:0]        ops [6] = '{17'h10000, 17'h00033, 17'h1ff00, 17'h00033, 17'h10000, 17'h00000};
  logic [7:0]         rix [5] = '{IDX_STATUS, IDX_PRIO_A, IDX_PRIO_B, IDX_MASK, 8'hfd};
  int                 fail_count, compares;
  eip_ctrl i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .external_request_input_n(pins),
    .request_sense_select(sense), .request_input_enable(en), .periph_req(preq), .exc_take(take),
    .exc_src(esrc), .cpu_req(creq), .cpu_src(csrc), .cpu_level(clvl), .irq_o(irq));
  eip_cpu_model i_cpu (.clk(clk), .rst_n(rst_n), .on(on), .dly(dly), .cpu_req(creq), .cpu_src(csrc),
    .exc_take(take), .exc_src(esrc));
  function automatic logic [31:0] rnd(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] ba(logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  function automatic logic [31:0] st(logic [3:0] x);
    return {26'h0, x[3], x[2], 2'b00, x[1], x[0]};
  endfunction
  // winner: {any, level, source}; lower source first within a level
  function automatic logic [5:0] win(logic [12:0] r, logic [7:0] a, logic [7:0] b);
    logic [12:0] lv;
    lv = {b[1], b[2], b[3], b[6], b[7], a[0], a[1], a[2], a[3], a[4], a[4], a[6], a[7]};
    for (int l = 1; l >= 0; l--)
      for (int i = 0; i < 13; i++)
        if (r[i] && lv[i] == l[0]) return {1'b1, l[0], i[3:0]};
    return 6'h0;
  endfunction
  task automatic wb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, wr, a, 24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic rchk(input logic [7:0] i, input logic [31:0] e);
    wb(1'b0, ba(i), 8'h0);
    chk("read", e, rd);
  endtask
  task automatic give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #1000000;
    fail_count++;
    give_verdict();
  end
  initial begin
    {rst_n, cyc, stb, we, on, dly, adr, wdat, sense, en, preq} = '0;
    pins = PIN_IDLE;
    lfsr = 32'hda28f4c2;
    fail_count = 0;
    compares = 0;
    // two edges suffice: the pin synchroniser resets to the idle level itself
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rix[i]) rchk(rix[i], 32'h0);
    repeat (8) begin
      lfsr = rnd(lfsr);
      preq <= lfsr[24:16] | 9'h100;
      wb(1'b1, ba(IDX_PRIO_A), lfsr[7:0]);
      wb(1'b1, ba(IDX_PRIO_B), lfsr[15:8]);
      rchk(IDX_PRIO_A, {24'h0, lfsr[7:0]});
      rchk(IDX_PRIO_B, {24'h0, lfsr[15:8]});
      w = win({preq, 4'h0}, lfsr[7:0], lfsr[15:8]);
      wb(1'b0, ba(IDX_PENDING), 8'h0);
      chk("pending", 32'({w, preq, 4'h0}), 32'({rd[31:30], rd[28:25], rd[12:0]}));
    end
    preq <= '0;
    pins <= 4'h0;
    repeat (6) @(posedge clk);
    pins <= PIN_IDLE;
    repeat (4) @(posedge clk);
    foreach (ops[i]) begin
      wb(ops[i][16], ba(IDX_STATUS), ops[i][15:8]);
      if (!ops[i][16]) chk("status", {24'h0, ops[i][7:0]}, rd);
    end
    sense <= 4'hf;
    repeat (4) begin
      lfsr = rnd(lfsr);
      pins <= lfsr[3:0];
      repeat (5) @(posedge clk);
      rchk(IDX_STATUS, st(~lfsr[3:0]));
      wb(1'b1, ba(IDX_STATUS), 8'h00);
      rchk(IDX_STATUS, 32'h0);
      pins <= PIN_IDLE;
      repeat (4) @(posedge clk);
    end
    wb(1'b1, ba(IDX_EVT), 8'hff);
    wb(1'b1, ba(IDX_MASK), 8'h01);
    chk("irq", 32'h0, {31'h0, irq});
    pins <= 4'he;
    repeat (6) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, ba(IDX_MASK), 8'h00);
    chk("irq", 32'h0, {31'h0, irq});
    wb(1'b1, ba(IDX_MASK), 8'h01);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, ba(IDX_EVT), 8'h01);
    chk("irq", 32'h0, {31'h0, irq});
    {on, en, sense, dly, pins} <= {1'b1, 4'hf, 4'h0, 4'h0, 4'h0};
    repeat (40) @(posedge clk);
    rchk(IDX_STATUS, 32'h33);
    pins <= PIN_IDLE;
    repeat (60) @(posedge clk);
    rchk(IDX_STATUS, 32'h0);
    // edge sense settles a cycle before the pins fall, so the edge is seen as such
    {sense, dly} <= {4'hf, 4'h7};
    @(posedge clk);
    pins <= 4'h0;
    repeat (60) @(posedge clk);
    rchk(IDX_STATUS, 32'h0);
    {en, pins} <= {4'h0, PIN_IDLE};
    repeat (4) @(posedge clk);
    pins <= 4'h0;
    repeat (30) @(posedge clk);
    rchk(IDX_STATUS, 32'h33);
    wb(1'b0, ba(IDX_PENDING), 8'h0);
    chk("forwarded", 32'h0, {18'h0, rd[31], rd[12:0]});
    give_verdict();
  end
endmodule
